/* File: include/sfe_defs.vh */
`ifndef SFE_DEFS_VH
`define SFE_DEFS_VH

// Command bytes.
`define SFE_CMD_ERASE_4K 8'h20
`define SFE_CMD_ERASE_32K 8'h52
`define SFE_CMD_ERASE_64K 8'hD8
`define SFE_CMD_ERASE_ALL_A 8'hC7
`define SFE_CMD_ERASE_ALL_B 8'h60
`define SFE_CMD_PAUSE 8'h75
`define SFE_CMD_RESUME 8'h7A
`define SFE_CMD_POWERDOWN 8'hB9
`define SFE_CMD_RELEASE 8'hAB
`define SFE_CMD_WRITE_ENABLE 8'h06
`define SFE_CMD_READ_STATUS 8'h05

// Status byte field positions.
`define SFE_ST_BUSY 0
`define SFE_ST_WEL 1
`define SFE_ST_PAUSED 7

// Region address widths (bits ignored below the region).
`define SFE_SHIFT_4K 12
`define SFE_SHIFT_32K 15
`define SFE_SHIFT_64K 16

// Clock period and times in ns.
`define SFE_CLK_NS 25
`define SFE_RESUME_NS 200
// Resume busy delay, longest time, rounded down.
`define SFE_RESUME_CYC (`SFE_RESUME_NS / `SFE_CLK_NS)

// Default cycle counts (parameters shorten them).
`define SFE_SMALL_ERASE_CYC 32'd2400000
`define SFE_MID_ERASE_CYC 32'd8000000
`define SFE_LARGE_ERASE_CYC 32'd14000000
`define SFE_FULL_ERASE_CYC 32'd1200000000
`define SFE_PAUSE_LAT_CYC 32'd800
`define SFE_PD_ENTRY_CYC 32'd120

`endif

/* File: design/sfe_core.v */
`timescale 1ns/1ps
`default_nettype none
`include "sfe_defs.vh"

module sfe_core #(
    parameter [31:0] SMALL_ERASE_CYC = `SFE_SMALL_ERASE_CYC,
    parameter [31:0] MID_ERASE_CYC = `SFE_MID_ERASE_CYC,
    parameter [31:0] LARGE_ERASE_CYC = `SFE_LARGE_ERASE_CYC,
    parameter [31:0] FULL_ERASE_CYC = `SFE_FULL_ERASE_CYC,
    parameter [31:0] PAUSE_LAT_CYC = `SFE_PAUSE_LAT_CYC,
    parameter [31:0] PD_ENTRY_CYC = `SFE_PD_ENTRY_CYC
) (
    // Clock and reset
    input wire i_ref_clk,
    input wire i_srst,
    // Serial link pins
    input wire i_cs_n,
    input wire i_sck,
    input wire i_si,
    output reg o_so,
    output reg o_so_oe,
    // Array erase request
    output reg o_erase_req,
    output reg [1:0] o_erase_size,
    output reg [23:0] o_erase_base,
    // Status view
    output reg o_busy,
    output reg o_write_enable_latch,
    output reg o_paused_op_flag,
    output reg o_powerdown
);

    // ****************************************
    // Constants
    // ****************************************
    localparam [1:0] SZ_4K = 2'd0;
    localparam [1:0] SZ_32K = 2'd1;
    localparam [1:0] SZ_64K = 2'd2;
    localparam [1:0] SZ_ALL = 2'd3;
    localparam [1:0] ST_IDLE = 2'd0;
    localparam [1:0] ST_ERASE = 2'd1;
    localparam [1:0] ST_PAUSE = 2'd2;
    localparam [1:0] ST_RESUME = 2'd3;
    localparam [31:0] RESUME_CYC = (`SFE_RESUME_CYC < 1) ? 32'd1 :
        `SFE_RESUME_CYC;

    function [31:0] erase_len;
        input [1:0] size;
        begin
            case (size)
                SZ_4K: erase_len = SMALL_ERASE_CYC;
                SZ_32K: erase_len = MID_ERASE_CYC;
                SZ_64K: erase_len = LARGE_ERASE_CYC;
                default: erase_len = FULL_ERASE_CYC;
            endcase
        end
    endfunction

    // ****************************************
    // Pin synchronisers and edge detect
    // ****************************************
    reg [1:0] cs_sync;
    reg [1:0] sck_sync;
    reg [1:0] si_sync;
    reg cs_q;
    reg sck_q;
    wire cs_rise = cs_sync[1] & ~cs_q;
    wire sck_rise = sck_sync[1] & ~sck_q & ~cs_sync[1];
    wire sck_fall = ~sck_sync[1] & sck_q & ~cs_sync[1];

    always @(posedge i_ref_clk) begin
        cs_sync <= {cs_sync[0], i_cs_n};
        sck_sync <= {sck_sync[0], i_sck};
        si_sync <= {si_sync[0], i_si};
        cs_q <= cs_sync[1];
        sck_q <= sck_sync[1];
    end

    // ****************************************
    // Frame shifter
    // ****************************************
    reg [2:0] bit_cnt;
    reg [2:0] byte_cnt;
    reg [7:0] shift;
    reg [7:0] opcode;
    reg [23:0] addr;
    wire [7:0] next_byte = {shift[6:0], si_sync[1]};
    wire at_boundary = (bit_cnt == 3'd0);

    always @(posedge i_ref_clk) begin
        if (i_srst || cs_sync[1]) begin
            bit_cnt <= 3'd0;
            byte_cnt <= 3'd0;
            shift <= 8'h00;
            opcode <= 8'h00;
            addr <= 24'h000000;
        end else if (sck_rise) begin
            bit_cnt <= bit_cnt + 3'd1;
            shift <= next_byte;
            if (bit_cnt == 3'd7) begin
                if (byte_cnt != 3'd7)
                    byte_cnt <= byte_cnt + 3'd1;
                if (byte_cnt == 3'd0)
                    opcode <= next_byte;
                else if (byte_cnt < 3'd4)
                    addr <= {addr[15:0], next_byte};
            end
        end
    end

    // ****************************************
    // Command decode at chip select rise
    // ****************************************
    wire one_byte = at_boundary && (byte_cnt == 3'd1);
    wire four_byte = at_boundary && (byte_cnt == 3'd4);
    wire is_sized = (opcode == `SFE_CMD_ERASE_4K) ||
        (opcode == `SFE_CMD_ERASE_32K) || (opcode == `SFE_CMD_ERASE_64K);
    wire is_all = (opcode == `SFE_CMD_ERASE_ALL_A) ||
        (opcode == `SFE_CMD_ERASE_ALL_B);
    wire erase_framed = cs_rise && ((is_sized && four_byte) ||
        (is_all && one_byte));
    wire cmd1 = cs_rise && one_byte;
    reg [1:0] state;
    reg [31:0] cnt;
    reg [1:0] cur_size;
    reg [23:0] cur_base;
    reg pd_pending;

    function [23:0] align;
        input [23:0] a;
        input [1:0] size;
        begin
            case (size)
                SZ_4K: align = {a[23:`SFE_SHIFT_4K], 12'h000};
                SZ_32K: align = {a[23:`SFE_SHIFT_32K], 15'h0000};
                SZ_64K: align = {a[23:`SFE_SHIFT_64K], 16'h0000};
                default: align = 24'h000000;
            endcase
        end
    endfunction

    reg [1:0] dec_size;
    always @* begin
        if (opcode == `SFE_CMD_ERASE_4K)
            dec_size = SZ_4K;
        else if (opcode == `SFE_CMD_ERASE_32K)
            dec_size = SZ_32K;
        else if (opcode == `SFE_CMD_ERASE_64K)
            dec_size = SZ_64K;
        else
            dec_size = SZ_ALL;
    end

    // ****************************************
    // Sequencer
    // ****************************************
    always @(posedge i_ref_clk) begin
        if (i_srst) begin
            state <= ST_IDLE;
            cnt <= 32'd0;
            cur_size <= SZ_4K;
            cur_base <= 24'h000000;
            pd_pending <= 1'b0;
            o_busy <= 1'b0;
            o_write_enable_latch <= 1'b0;
            o_paused_op_flag <= 1'b0;
            o_powerdown <= 1'b0;
            o_erase_req <= 1'b0;
            o_erase_size <= SZ_4K;
            o_erase_base <= 24'h000000;
        end else begin
            o_erase_req <= 1'b0;
            if (o_powerdown) begin
                if (cmd1 && opcode == `SFE_CMD_RELEASE)
                    o_powerdown <= 1'b0;
            end else if (pd_pending) begin
                if (cnt >= PD_ENTRY_CYC - 32'd1) begin
                    pd_pending <= 1'b0;
                    o_powerdown <= 1'b1;
                    cnt <= 32'd0;
                end else begin
                    cnt <= cnt + 32'd1;
                end
            end else begin
                case (state)
                    ST_IDLE: begin
                        if (cmd1 && opcode == `SFE_CMD_WRITE_ENABLE) begin
                            o_write_enable_latch <= 1'b1;
                        end else if (erase_framed && o_write_enable_latch &&
                                !o_paused_op_flag) begin
                            state <= ST_ERASE;
                            o_busy <= 1'b1;
                            o_write_enable_latch <= 1'b0;
                            cnt <= 32'd0;
                            cur_size <= dec_size;
                            cur_base <= align(addr, dec_size);
                        end else if (cmd1 &&
                                opcode == `SFE_CMD_POWERDOWN) begin
                            pd_pending <= 1'b1;
                            cnt <= 32'd0;
                        end
                    end
                    ST_ERASE: begin
                        if (cmd1 && opcode == `SFE_CMD_PAUSE &&
                                cur_size != SZ_ALL) begin
                            o_paused_op_flag <= 1'b1;
                            state <= ST_PAUSE;
                        end else if (cnt >= erase_len(cur_size) - 32'd1) begin
                            state <= ST_IDLE;
                            o_busy <= 1'b0;
                            o_erase_req <= 1'b1;
                            o_erase_size <= cur_size;
                            o_erase_base <= cur_base;
                        end else begin
                            cnt <= cnt + 32'd1;
                        end
                    end
                    ST_PAUSE: begin
                        if (o_busy) begin
                            o_busy <= 1'b0;
                        end else if (cmd1 && opcode == `SFE_CMD_RESUME) begin
                            o_paused_op_flag <= 1'b0;
                            state <= ST_RESUME;
                        end else if (cmd1 &&
                                opcode == `SFE_CMD_WRITE_ENABLE) begin
                            o_write_enable_latch <= 1'b1;
                        end
                    end
                    default: begin
                        o_busy <= 1'b1;
                        state <= ST_ERASE;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Status read output
    // ****************************************
    reg [7:0] st_shift;
    reg reading;
    always @(posedge i_ref_clk) begin
        if (i_srst || cs_sync[1]) begin
            reading <= 1'b0;
            st_shift <= 8'h00;
            o_so <= 1'b0;
            o_so_oe <= 1'b0;
        end else if (sck_fall) begin
            if (!reading && byte_cnt == 3'd1 && at_boundary &&
                    opcode == `SFE_CMD_READ_STATUS && !o_powerdown) begin
                reading <= 1'b1;
                o_so_oe <= 1'b1;
                o_so <= o_paused_op_flag;
                st_shift <= {o_paused_op_flag, 5'b00000,
                    o_write_enable_latch, o_busy} << 1;
            end else if (reading) begin
                o_so <= st_shift[7];
                st_shift <= {st_shift[6:0], st_shift[7]};
                if (at_boundary)
                    st_shift <= {o_paused_op_flag, 5'b00000,
                        o_write_enable_latch, o_busy} << 1;
                if (at_boundary)
                    o_so <= o_paused_op_flag;
            end
        end
    end

endmodule
`default_nettype wire

/* File: testbench/sfe_core_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module sfe_props (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_srst,
    // Watched outputs
    input wire logic o_so_oe,
    input wire logic o_erase_req,
    input wire logic [1:0] o_erase_size,
    input wire logic [23:0] o_erase_base,
    input wire logic o_busy,
    input wire logic o_write_enable_latch,
    input wire logic o_paused_op_flag,
    input wire logic o_powerdown
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_srst);
    a_latch_clears: assert property (
        $rose(o_busy) && !$past(o_paused_op_flag, 2)
        |-> !o_write_enable_latch) else $error("latch set at busy");
    a_erase_done: assert property (
        o_erase_req |-> $past(o_busy) && !o_busy) else $error("req timing");
    a_busy_end: assert property (
        $fell(o_busy) |-> o_erase_req || o_paused_op_flag)
        else $error("busy fell early");
    a_pause_entry: assert property (
        $rose(o_paused_op_flag) |-> $past(o_busy)) else $error("bad pause");
    a_pause_latency: assert property (
        $rose(o_paused_op_flag) |-> ##[0:1] !o_busy) else $error("busy kept");
    a_resume_busy: assert property (
        $fell(o_paused_op_flag) |-> !$past(o_busy) ##[1:8] o_busy)
        else $error("bad resume");
    a_pd_quiet: assert property (
        o_powerdown |-> !o_busy && !o_so_oe) else $error("active asleep");
    a_clean_start: assert property (
        $fell(i_srst) |-> !o_powerdown && !o_paused_op_flag)
        else $error("bad start");
    a_base_aligned: assert property (
        o_erase_req && o_erase_size != 2'h3
        |-> o_erase_base[11:0] == 12'h000
        && (o_erase_size == 2'h0 || o_erase_base[14:12] == 3'h0)
        && (o_erase_size != 2'h2 || o_erase_base[15] == 1'b0))
        else $error("base not aligned");
endmodule
bind sfe_core sfe_props u_props (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
    .o_so_oe(o_so_oe), .o_erase_req(o_erase_req),
    .o_erase_size(o_erase_size), .o_erase_base(o_erase_base),
    .o_busy(o_busy), .o_write_enable_latch(o_write_enable_latch),
    .o_paused_op_flag(o_paused_op_flag), .o_powerdown(o_powerdown));
`default_nettype wire

/* File: testbench/sfe_host.sv */
`timescale 1ns/1ps
`default_nettype none
module sfe_host (
    // Clock and returned data
    input wire logic i_ref_clk,
    input wire logic i_so,
    // Link drive and captured byte
    output logic o_cs_n,
    output logic o_sck,
    output logic o_si,
    output logic [7:0] o_rx
);
    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_si = 1'b0;
        o_rx = 8'h00;
    end
    task automatic send(input logic [31:0] d, input int nb);
        @(posedge i_ref_clk);
        o_cs_n <= 1'b0;
        for (int k = nb - 1; k >= 0; k--) begin
            @(posedge i_ref_clk);
            o_si <= d[k];
            repeat (4) @(posedge i_ref_clk);
            o_sck <= 1'b1;
            o_rx <= {o_rx[6:0], i_so};
            repeat (4) @(posedge i_ref_clk);
            o_sck <= 1'b0;
        end
        repeat (4) @(posedge i_ref_clk);
        o_cs_n <= 1'b1;
        o_si <= ~o_si;
        repeat (6) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
    endtask
endmodule
`default_nettype wire

/* File: testbench/sfe_core_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sfe_defs.vh"
module sfe_core_tb_top;
    logic clk, rst, cs_n, sck, si, so, so_oe, req, busy, write_enable_latch, paused, pd;
    logic [1:0] size;
    logic [23:0] base;
    logic [7:0] rx;
    logic so_line;
    logic [3:0] fl;
    int fails = 0, compares = 0, bc = 0;
    assign fl = {paused, pd, req, busy};
    // A released SO line reads high, since o_so is cleared whenever o_so_oe is.
    assign so_line = so_oe ? so : ~so;
    sfe_core #(.SMALL_ERASE_CYC(400), .MID_ERASE_CYC(420),
        .LARGE_ERASE_CYC(440), .FULL_ERASE_CYC(460),
        .PD_ENTRY_CYC(50)) uut (.i_ref_clk(clk), .i_srst(rst),
        .i_cs_n(cs_n), .i_sck(sck), .i_si(si), .o_so(so), .o_so_oe(so_oe),
        .o_erase_req(req), .o_erase_size(size), .o_erase_base(base),
        .o_busy(busy), .o_write_enable_latch(write_enable_latch),
        .o_paused_op_flag(paused), .o_powerdown(pd));
    sfe_host host (.i_ref_clk(clk), .i_so(so_line), .o_cs_n(cs_n),
        .o_sck(sck),
        .o_si(si), .o_rx(rx));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) if (busy === 1'b1) bc <= bc + 1;
    task automatic chk(input string nm, input logic [31:0] got, exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task automatic report_and_stop;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Waits at falling edges until flag k reaches v or the limit runs out.
    task automatic await(input int k, input logic v, input int lim);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (fl[k] !== v && n < lim);
    endtask
    task automatic do_reset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic t_start;
        do_reset;
        chk("reset", {pd, paused, busy, write_enable_latch}, 4'h0);
        $display("t_start done");
    endtask
    task automatic t_sized;
        logic [7:0] op [5] = '{`SFE_CMD_ERASE_4K, `SFE_CMD_ERASE_32K,
            `SFE_CMD_ERASE_64K, `SFE_CMD_ERASE_ALL_A, `SFE_CMD_ERASE_ALL_B};
        logic [23:0] bx [3] = '{24'hA5B000, 24'hA58000, 24'hA50000};
        int tx [5] = '{400, 420, 440, 460, 460};
        int b0;
        for (int i = 0; i < 5; i++) begin
            host.send(`SFE_CMD_WRITE_ENABLE, 8);
            chk("latch set", write_enable_latch, 1'b1);
            b0 = bc;
            host.send(i > 2 ? {24'h0, op[i]} : {op[i], 24'hA5B6C7},
                i > 2 ? 8 : 32);
            await(0, 1'b1, 8);
            chk("latch clear", write_enable_latch, 1'b0);
            host.send({`SFE_CMD_READ_STATUS, 8'h00}, 16);
            chk("status", rx, 8'h01);
            await(1, 1'b1, 600);
            chk("erase time", bc - b0, tx[i]);
            chk("size", size, i > 2 ? 3 : i);
            if (i < 3) chk("base", base, bx[i]);
        end
        $display("t_sized done");
    endtask
    task automatic t_refuse;
        host.send({`SFE_CMD_ERASE_4K, 24'h0}, 32);
        await(0, 1'b1, 8);
        chk("no latch", busy, 1'b0);
        host.send(`SFE_CMD_WRITE_ENABLE, 8);
        host.send({`SFE_CMD_ERASE_4K, 24'h0} >> 1, 31);
        await(0, 1'b1, 8);
        chk("short frame", {busy, write_enable_latch}, 2'h1);
        host.send(`SFE_CMD_PAUSE, 8);
        host.send(`SFE_CMD_RESUME, 8);
        chk("idle pause", {busy, paused}, 2'h0);
        $display("t_refuse done");
    endtask
    task automatic t_pause;
        host.send(`SFE_CMD_WRITE_ENABLE, 8);
        host.send({`SFE_CMD_ERASE_64K, 24'h010000}, 32);
        host.send(`SFE_CMD_RESUME, 8);
        chk("busy resume", {busy, paused}, 2'h2);
        host.send(`SFE_CMD_PAUSE, 8);
        chk("paused", {busy, paused}, 2'h1);
        host.send({`SFE_CMD_READ_STATUS, 8'h00}, 16);
        chk("paused status", rx, 8'h80);
        host.send(`SFE_CMD_RESUME, 8);
        chk("resumed", {busy, paused}, 2'h2);
        await(1, 1'b1, 600);
        chk("finish", size, 2'h2);
        host.send(`SFE_CMD_WRITE_ENABLE, 8);
        host.send(`SFE_CMD_ERASE_ALL_A, 8);
        host.send(`SFE_CMD_PAUSE, 8);
        chk("array pause", {busy, paused}, 2'h2);
        await(1, 1'b1, 600);
        host.send(`SFE_CMD_WRITE_ENABLE, 8);
        host.send({`SFE_CMD_ERASE_32K, 24'h0}, 32);
        host.send(`SFE_CMD_PAUSE, 8);
        // reset while paused drops the paused erase and clears the paused flag
        do_reset;
        host.send(`SFE_CMD_RESUME, 8);
        chk("power loss", {busy, paused}, 2'h0);
        $display("t_pause done");
    endtask
    task automatic t_pd;
        host.send({`SFE_CMD_POWERDOWN, 1'b0}, 9);
        await(2, 1'b1, 80);
        chk("odd frame", pd, 1'b0);
        host.send(`SFE_CMD_POWERDOWN, 8);
        await(2, 1'b1, 80);
        chk("sleep", pd, 1'b1);
        host.send(`SFE_CMD_WRITE_ENABLE, 8);
        chk("sleep deaf", write_enable_latch, 1'b0);
        host.send({`SFE_CMD_READ_STATUS, 8'h00}, 16);
        chk("sleep status", rx, 8'hFF);
        host.send(`SFE_CMD_RELEASE, 8);
        chk("wake", pd, 1'b0);
        host.send(`SFE_CMD_WRITE_ENABLE, 8);
        chk("awake", write_enable_latch, 1'b1);
        host.send({`SFE_CMD_READ_STATUS, 8'h00}, 16);
        chk("awake status", rx, 8'h02);
        $display("t_pd done");
    endtask
    initial begin
        #2000000;
        fails++;
        report_and_stop;
    end
    initial begin
        rst = 1'b1;
        t_start;
        t_sized;
        t_refuse;
        t_pause;
        t_pd;
        report_and_stop;
    end
endmodule
`default_nettype wire
